// *** common/atis_defs.svh ***
// constants for the per-axis trigger input select block
`ifndef ATIS_DEFS_SVH
`define ATIS_DEFS_SVH
`define ATIS_NUM_AXES      8
// setting encoding: {enable, polarity}; polarity 1 = active transition
`define ATIS_SET_W         2
`define ATIS_SET_EN_BIT    1
`define ATIS_SET_POL_BIT   0
`define ATIS_SET_RESET     2'h3
`define ATIS_SET_OFF       2'h0
`define ATIS_SET_ACTIVE    2'h3
`define ATIS_SET_INACTIVE  2'h2
`define ATIS_SYNC_STAGES   3
`endif

// *** common/atis_pkg.sv ***
// types for the per-axis trigger input select block
package atis_pkg;
  typedef logic [1:0] atis_setting_t;
  typedef enum logic [1:0] {
    ATIS_CODE_OFF,
    ATIS_CODE_ACTIVE,
    ATIS_CODE_INACTIVE,
    ATIS_CODE_KEEP
  } atis_code_t;
endpackage

// *** core/atis_trigger_select.sv ***
// per-axis trigger input select: settings, pin sync, edge triggers
`timescale 1ns/1ns
`default_nettype none
`include "atis_defs.svh"
module atis_trigger_select #(
  parameter int NUM_AXES = `ATIS_NUM_AXES
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // setting write: mask of axes, per-axis code
  input  wire logic [NUM_AXES-1:0]   wr_mask_i,
  input  wire atis_pkg::atis_code_t  wr_code_i [NUM_AXES],
  // read selection
  input  wire logic [2:0]            rd_axis_i,
  output logic                       rd_state_o,
  output logic [NUM_AXES-1:0]        pin_state_o,
  // settings readback
  output logic [NUM_AXES-1:0]        set_en_o,
  output logic [NUM_AXES-1:0]        set_pol_o,
  // trigger pins and encoder index, asynchronous
  input  wire logic [NUM_AXES-1:0]   trigger_a_pin_i,
  input  wire logic [NUM_AXES-1:0]   index_pin_i,
  // motion engine cycle status and configuration
  input  wire logic [NUM_AXES-1:0]   home_seek_cycle_i,
  input  wire logic [NUM_AXES-1:0]   registration_move_cycle_i,
  input  wire logic [NUM_AXES-1:0]   follower_registration_cycle_i,
  input  wire logic [NUM_AXES-1:0]   index_qual_en_i,
  // trigger pulses
  output logic [NUM_AXES-1:0]        home_trig_o,
  output logic [NUM_AXES-1:0]        reg_trig_o,
  output logic [NUM_AXES-1:0]        index_start_o
);

  // edge on pin selected by polarity: pol=1 rising, pol=0 falling
  function automatic logic sel_edge(input logic rise, input logic fall,
                                    input logic pol);
    sel_edge = pol ? rise : fall;
  endfunction

  // filtered level: follows stage three once two and three agree
  function automatic logic [NUM_AXES-1:0] filt(
    input logic [NUM_AXES-1:0] st2,
    input logic [NUM_AXES-1:0] st3,
    input logic [NUM_AXES-1:0] prev
  );
    filt = (~(st2 ^ st3) & st3) | ((st2 ^ st3) & prev);
  endfunction

  // reset setting split into its fields
  localparam atis_pkg::atis_setting_t RST_SET = `ATIS_SET_RESET;
  localparam logic RST_EN  = RST_SET[`ATIS_SET_EN_BIT];
  localparam logic RST_POL = RST_SET[`ATIS_SET_POL_BIT];

  logic [NUM_AXES-1:0] s1_q, s2_q, s3_q, pin_q;
  logic [NUM_AXES-1:0] x1_q, x2_q, x3_q, idx_q;
  logic [NUM_AXES-1:0] en_q, en_d, pol_q, pol_d;
  logic [NUM_AXES-1:0] pin_rise, pin_fall, idx_rise;
  logic [NUM_AXES-1:0] reg_cyc, trig_edge, arm_q, arm_d;
  logic [NUM_AXES-1:0] home_d, reg_d;
  logic [NUM_AXES-1:0] home_q, reg_q;
  logic [NUM_AXES-1:0] pin_new, idx_new, qual_hit, fire;

  // three-stage sync; change accepted when stages two and three agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
      x1_q  <= '0;
      x2_q  <= '0;
      x3_q  <= '0;
      idx_q <= '0;
    end else begin
      s1_q  <= trigger_a_pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_new;
      x1_q  <= index_pin_i;
      x2_q  <= x1_q;
      x3_q  <= x2_q;
      idx_q <= idx_new;
    end
  end

  assign pin_new  = filt(s2_q, s3_q, pin_q);
  assign idx_new  = filt(x2_q, x3_q, idx_q);
  assign pin_rise = pin_new & ~pin_q;
  assign pin_fall = ~pin_new & pin_q;
  assign idx_rise = idx_new & ~idx_q;
  assign reg_cyc  = registration_move_cycle_i | follower_registration_cycle_i;

  // settings update
  always_comb begin
    en_d  = en_q;
    pol_d = pol_q;
    for (int a = 0; a < NUM_AXES; a++) begin
      if (wr_mask_i[a]) begin
        case (wr_code_i[a])
          atis_pkg::ATIS_CODE_ACTIVE: begin
            en_d[a]  = 1'b1;
            pol_d[a] = 1'b1;
          end
          atis_pkg::ATIS_CODE_INACTIVE: begin
            en_d[a]  = 1'b1;
            pol_d[a] = 1'b0;
          end
          atis_pkg::ATIS_CODE_OFF: begin
            if (!reg_cyc[a]) begin
              en_d[a] = 1'b0;
            end
          end
          default: begin
            en_d[a] = en_q[a];
          end
        endcase
      end
    end
  end

  // trigger edge, optionally armed by pin edge then qualified by index
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      trig_edge[a] = sel_edge(pin_rise[a], pin_fall[a], pol_q[a]);
    end
  end

  always_comb begin
    arm_d = arm_q;
    for (int a = 0; a < NUM_AXES; a++) begin
      if (!(home_seek_cycle_i[a] | reg_cyc[a]) | !index_qual_en_i[a]) begin
        arm_d[a] = 1'b0;
      end else if (arm_q[a] & idx_rise[a]) begin
        arm_d[a] = 1'b0;
      end else if (trig_edge[a]) begin
        arm_d[a] = 1'b1;
      end
    end
  end

  assign qual_hit = index_qual_en_i & arm_q & idx_rise;
  assign fire     = (~index_qual_en_i & trig_edge) | qual_hit;
  assign home_d = home_seek_cycle_i & fire;
  assign reg_d  = reg_cyc & en_q & fire;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q   <= {NUM_AXES{RST_EN}};
      pol_q  <= {NUM_AXES{RST_POL}};
      arm_q  <= '0;
      home_q <= '0;
      reg_q  <= '0;
    end else begin
      en_q   <= en_d;
      pol_q  <= pol_d;
      arm_q  <= arm_d;
      home_q <= home_d;
      reg_q  <= reg_d;
    end
  end

  assign home_trig_o   = home_q;
  assign reg_trig_o    = reg_q;
  assign index_start_o = reg_q;
  assign pin_state_o   = pin_q;
  assign rd_state_o    = pin_q[rd_axis_i];
  assign set_en_o      = en_q;
  assign set_pol_o     = pol_q;

  // assertions: one clock domain, quiet during reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_home_no_disable: assert property (
    (home_seek_cycle_i & ~index_qual_en_i & trig_edge) != '0 |=>
      (home_trig_o != '0))
    else $error("home trigger missed");
  a_reg_off_silent: assert property (
    (reg_trig_o & ~$past(en_q)) == '0)
    else $error("registration fired while disabled");
  a_no_disable_cyc: assert property (
    (reg_cyc & en_q & ~en_d) == '0)
    else $error("registration disabled mid cycle");
  a_index_start: assert property (
    index_start_o == reg_trig_o)
    else $error("index start not tied to trigger");
  a_single_pulse: assert property (
    (reg_trig_o != '0) |=> ((reg_trig_o & $past(reg_trig_o)) == '0))
    else $error("trigger pulse too long");
  a_enable_write: assert property (
    (wr_mask_i[0] && wr_code_i[0] == atis_pkg::ATIS_CODE_ACTIVE) |=>
      (en_q[0] && pol_q[0]))
    else $error("enable write dropped");
  a_pol_active: assert property (
    (reg_cyc[0] && en_q[0] && pol_q[0] && !index_qual_en_i[0]
      && pin_rise[0]) |=> reg_trig_o[0])
    else $error("active edge missed");
  a_pol_inactive: assert property (
    (home_seek_cycle_i[0] && !pol_q[0] && !index_qual_en_i[0]
      && pin_fall[0]) |=> home_trig_o[0])
    else $error("inactive edge missed");

  // per-axis checks, built from the steps of each trigger
  for (genvar g = 0; g < NUM_AXES; g++) begin : g_chk
    sequence s_live_edge;
      !index_qual_en_i[g] && trig_edge[g];
    endsequence
    sequence s_home_step;
      home_seek_cycle_i[g] ##0 s_live_edge;
    endsequence
    sequence s_reg_step;
      (reg_cyc[g] && en_q[g]) ##0 s_live_edge;
    endsequence
    sequence s_armed_index;
      index_qual_en_i[g] && arm_q[g] && idx_rise[g];
    endsequence
    sequence s_off_write;
      wr_mask_i[g] && wr_code_i[g] == atis_pkg::ATIS_CODE_OFF;
    endsequence
    sequence s_keep_write;
      wr_mask_i[g] && wr_code_i[g] == atis_pkg::ATIS_CODE_KEEP;
    endsequence

    // trigger firing
    a_home_edge: assert property (
      s_home_step |=> home_trig_o[g])
      else $error("home edge missed");
    a_home_no_en: assert property (
      !en_q[g] ##0 s_home_step |=> home_trig_o[g])
      else $error("home trigger lost while disabled");
    a_reg_edge: assert property (
      s_reg_step |=> reg_trig_o[g])
      else $error("registration edge missed");
    a_home_in_cycle: assert property (
      home_trig_o[g] |-> $past(home_seek_cycle_i[g]))
      else $error("home trigger outside home seek");
    a_reg_in_cycle: assert property (
      reg_trig_o[g] |-> $past(reg_cyc[g] && en_q[g]))
      else $error("registration trigger outside cycle");

    // index qualification
    a_home_qual: assert property (
      home_seek_cycle_i[g] ##0 s_armed_index |=> home_trig_o[g])
      else $error("qualified home trigger missed");
    a_reg_qual: assert property (
      (reg_cyc[g] && en_q[g]) ##0 s_armed_index |=> reg_trig_o[g])
      else $error("qualified registration trigger missed");
    a_qual_waits: assert property (
      (index_qual_en_i[g] && !arm_q[g]) |=>
        (!home_trig_o[g] && !reg_trig_o[g]))
      else $error("qualified trigger fired without arming");
    a_arm_clear: assert property (
      !(home_seek_cycle_i[g] || reg_cyc[g]) |=> !arm_q[g])
      else $error("arm held outside a cycle");
    a_arm_set: assert property (
      (index_qual_en_i[g] && (home_seek_cycle_i[g] || reg_cyc[g])
        && trig_edge[g] && !(arm_q[g] && idx_rise[g])) |=> arm_q[g])
      else $error("qualified edge did not arm");

    // settings writes
    a_active_write: assert property (
      (wr_mask_i[g] && wr_code_i[g] == atis_pkg::ATIS_CODE_ACTIVE)
        |=> (en_q[g] && pol_q[g]))
      else $error("active write dropped");
    a_inactive_write: assert property (
      (wr_mask_i[g] && wr_code_i[g] == atis_pkg::ATIS_CODE_INACTIVE)
        |=> (en_q[g] && !pol_q[g]))
      else $error("inactive write dropped");
    a_off_write: assert property (
      (!reg_cyc[g]) ##0 s_off_write |=> !en_q[g])
      else $error("disable write dropped");
    a_off_refused: assert property (
      (reg_cyc[g] && en_q[g]) ##0 s_off_write |=> en_q[g])
      else $error("disable write taken mid cycle");
    a_keep_write: assert property (
      s_keep_write |=> (en_q[g] == $past(en_q[g])
        && pol_q[g] == $past(pol_q[g])))
      else $error("keep write changed setting");

    // filtered pin and read
    a_pin_settle: assert property (
      (s2_q[g] == s3_q[g]) |=> pin_state_o[g] == $past(s3_q[g]))
      else $error("filtered pin missed settled level");
    a_pin_glitch: assert property (
      (s2_q[g] != s3_q[g]) |=> $stable(pin_state_o[g]))
      else $error("filtered pin followed a disagreement");
    a_rd_state: assert property (
      (rd_axis_i == g) |-> rd_state_o == pin_state_o[g])
      else $error("read state not the selected pin");
  end

endmodule
`default_nettype wire

// *** tb/atis_sensor_model.sv ***
// switch or sensor on the trigger pins, with contact delay
`timescale 1ns/1ns
`default_nettype none
module atis_sensor_model (
  // requested switch level
  input  wire logic [7:0] level_i,
  // pin seen by the block, changes off the clock
  output logic      [7:0] pin_o
);
  assign #37 pin_o = level_i;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// bench for the per-axis trigger input select block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i = 0, rst_i = 1;
  logic [7:0] m = 0, lvl = 0, pin, idx = 0, hs = 0, rg = 0, fl = 0, q = 0;
  logic [2:0] ax = 0;
  atis_pkg::atis_code_t code [8];
  logic rd;
  logic [7:0] ps, en, pol, ht, rt, is;
  int miscompares = 0, checked = 0, cyc = 0, hc = 0, rc = 0, ic = 0;
  always #50 clk_i = ~clk_i;
  atis_sensor_model i_atis_sensor_model (.level_i(lvl), .pin_o(pin));
  atis_trigger_select i_atis_trigger_select (
    .clk_i(clk_i), .rst_i(rst_i), .wr_mask_i(m), .wr_code_i(code),
    .rd_axis_i(ax), .rd_state_o(rd), .pin_state_o(ps), .set_en_o(en),
    .set_pol_o(pol), .trigger_a_pin_i(pin), .index_pin_i(idx),
    .home_seek_cycle_i(hs), .registration_move_cycle_i(rg),
    .follower_registration_cycle_i(fl), .index_qual_en_i(q),
    .home_trig_o(ht), .reg_trig_o(rt), .index_start_o(is));
  always @(posedge clk_i) begin
    hc <= hc + (ht[0] === 1'b1);
    rc <= rc + (rt[0] === 1'b1);
    ic <= ic + (is[0] === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: saw %0h wanted %0h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] k, input atis_pkg::atis_code_t c);
    @(posedge clk_i);
    foreach (code[i]) code[i] <= c;
    m <= k;
    @(posedge clk_i);
    m <= 8'h00;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic pn(input logic [7:0] v);
    lvl <= v;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    foreach (code[i]) code[i] = atis_pkg::ATIS_CODE_KEEP;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    chk(en, 8'hff);
    chk(pol, 8'hff);
    wr(8'h06, atis_pkg::ATIS_CODE_INACTIVE);
    chk({en, pol}, 16'hfff9);
    wr(8'h06, atis_pkg::ATIS_CODE_KEEP);
    chk({en, pol}, 16'hfff9);
    wr(8'hff, atis_pkg::ATIS_CODE_OFF);
    chk(en, 8'h00);
    wr(8'hff, atis_pkg::ATIS_CODE_ACTIVE);
    chk({en, pol}, 16'hffff);
    $display("settings test done");
    hs <= 8'h01;
    pn(8'h01);
    chk(rd, 1'b1);
    chk(ps, 8'h01);
    chk(hc, 1);
    pn(8'h00);
    chk(hc, 1);
    wr(8'h01, atis_pkg::ATIS_CODE_INACTIVE);
    pn(8'h01);
    pn(8'h00);
    chk(hc, 2);
    wr(8'h01, atis_pkg::ATIS_CODE_OFF);
    pn(8'h01);
    pn(8'h00);
    chk(hc, 3);
    $display("home test done");
    hs <= 8'h00;
    wr(8'h01, atis_pkg::ATIS_CODE_ACTIVE);
    rg <= 8'h01;
    pn(8'h01);
    chk({rc, ic}, {32'd1, 32'd1});
    wr(8'h01, atis_pkg::ATIS_CODE_OFF);
    chk(en[0], 1'b1);
    wr(8'h01, atis_pkg::ATIS_CODE_INACTIVE);
    chk(pol[0], 1'b0);
    pn(8'h00);
    chk(rc, 2);
    rg <= 8'h00;
    fl <= 8'h01;
    pn(8'h01);
    pn(8'h00);
    chk({rc, ic}, {32'd3, 32'd3});
    $display("registration test done");
    fl <= 8'h00;
    wr(8'h01, atis_pkg::ATIS_CODE_ACTIVE);
    q <= 8'h01;
    rg <= 8'h01;
    pn(8'h01);
    chk(rc, 3);
    idx <= 8'h01;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk(rc, 4);
    $display("index test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
